// File: src/encoder_output_defs.svh
// Offsets, field positions, reset values for the encoder output block.
// Assumes inclusion by bare name from the design files.
`ifndef ENCODER_OUTPUT_DEFS_SVH
`define ENCODER_OUTPUT_DEFS_SVH

// ============================================================
// Memory word addresses
`define ADDR_ZERO_POINT 4'h6
`define ADDR_QUAD_CONFIG 4'h7
`define ADDR_LOCK 4'h8
`define ADDR_DIAG 4'h9
`define ADDR_COMM_CONFIG 4'ha

// ============================================================
// Quadrature config word fields
`define QC_DIR_BIT 9
`define QC_ZMODE_BIT 8
`define QC_EN_BIT 7
`define QC_HYS_MSB 6
`define QC_HYS_LSB 4
`define QC_RES_MSB 3
`define QC_RES_LSB 0

// ============================================================
// Commutation config word fields
`define CC_EN_BIT 6
`define CC_HYS_MSB 5
`define CC_HYS_LSB 3
`define CC_CNT_MSB 2
`define CC_CNT_LSB 0

// ============================================================
// Reset values
`define RST_ZERO_POINT 12'h000
`define RST_QUAD_CONFIG 12'h0a0
`define RST_LOCK 2'h3
`define RST_DIAG 2'h0
`define RST_COMM_CONFIG 7'h52
`define LOCK_OPEN 2'h3

`endif

// File: src/encoder_output_pkg.sv
// Types and shared decode for the encoder output block.
// Assumes nothing beyond a SystemVerilog compiler.
package encoder_output_pkg;

  typedef logic [11:0] word_t;

  typedef enum logic [1:0] {
    FILT_BYPASS,
    FILT_THRESHOLD
  } filt_kind_t;

  // Hysteresis code to update threshold in LSB, 0 means bypass
  function automatic logic [2:0] hys_threshold(input logic [2:0] code);
    logic [2:0] thr;
    thr = 3'h3;
    case (code)
      3'h0: thr = 3'h0;
      3'h1: thr = 3'h2;
      3'h3: thr = 3'h4;
      3'h4: thr = 3'h5;
      default: thr = 3'h3;
    endcase
    return thr;
  endfunction

endpackage

// File: src/angle_hysteresis_filter.sv
// Hysteresis filter on a wrapping angle.
// Assumes angle_in is synchronous to clk_in.
`timescale 1ns/1ps

module angle_hysteresis_filter
  import encoder_output_pkg::*;
#(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Setting and angle
  input wire logic [2:0] hys_code_in,
  input wire logic [WIDTH-1:0] angle_in,
  output logic [WIDTH-1:0] angle_out
);

  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] step;
  logic [WIDTH-1:0] mag;
  logic [2:0] thr;
  filt_kind_t kind;

  always_comb begin
    thr = hys_threshold(hys_code_in);
    kind = (thr == 3'h0) ? FILT_BYPASS : FILT_THRESHOLD;
    step = angle_in - held;
    mag = step[WIDTH-1] ? (~step + {{(WIDTH-1){1'b0}}, 1'b1}) : step;
  end

  // Held angle moves only once the shift reaches the threshold
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      held <= '0;
    end else if (kind == FILT_BYPASS) begin
      held <= angle_in; // [RULE_17]
    end else if (mag >= {{(WIDTH-3){1'b0}}, thr}) begin
      held <= angle_in; // [RULE_17] [RULE_05]
    end
  end

  assign angle_out = held;

endmodule

// File: src/abz_uvw_encoder_output.sv
// Quadrature and commutation outputs from the absolute angle, with stored settings.
// Assumes the angle and memory port are synchronous to clk_in.
//
// What this block does
// RULE_01: Quadrature resolution code selects 1024 down to 50 pulses; default code 0.
// RULE_02: Lock field defaults open; any other stored value blocks all later writes.
// RULE_03: Diagnosis bit 1 disables flux check, bit 0 tracking check; default enabled.
// RULE_04: Commutation enable low floats U, V, W; high (default) drives them.
// RULE_05: Commutation hysteresis codes map to off, 0, 1, 2, 3 LSB; default 1.
// RULE_06: Commutation pulses per turn are count field plus one; default three.
// RULE_07: Z pulses at zero in normal mode; switch mode high below half turn.
// RULE_08: Index position follows the programmed zero point.
// RULE_09: Scaled quadrature angle is angle times four times resolution over 4096.
// RULE_10: A is bit 1, B is bit 1 xor bit 0, Z is NOR of all.
// RULE_11: Commutation waveform starts at the programmed zero point.
// RULE_12: Commutation uses its own hysteresis, separate from quadrature.
// RULE_13: Scaled commutation angle is angle times six times pulses over 4096.
// RULE_14: U high for scaled angle 6N and 6N+1, else low.
// RULE_15: V high for scaled angle 6N+2 and 6N+3, else low.
// RULE_16: W low for scaled angle 6N+1 and 6N+2, else high.
// RULE_17: Filter off follows angle; 0 LSB needs two-LSB move to update.
// RULE_18: Quadrature enable low floats A, B, Z; high (default) drives them.
// RULE_19: Stored words copy to working settings at power-up and normal-mode entry.
// RULE_20: Zero point and direction are applied before either scaling.
// RULE_21: Outputs computed from filtered angle each cycle and registered.
`timescale 1ns/1ps
`include "encoder_output_defs.svh"

module abz_uvw_encoder_output
  import encoder_output_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Angle from the tracking loop
  input wire logic [11:0] absolute_angle_in,
  // Normal-mode entry strobe
  input wire logic normal_mode_entry_in,
  // Stored memory access
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [3:0] mem_addr_in,
  input wire logic [11:0] mem_wdata_in,
  output logic [11:0] mem_rdata_out,
  output logic mem_wr_refused_out,
  output logic mem_locked_out,
  // Diagnosis enables
  output logic flux_check_en_out,
  output logic tracking_check_en_out,
  // Quadrature pins
  output logic quad_a_out,
  output logic quad_b_out,
  output logic quad_z_out,
  output logic quad_oe_out,
  // Commutation pins
  output logic comm_u_out,
  output logic comm_v_out,
  output logic comm_w_out,
  output logic comm_oe_out
);

  // ============================================================
  // Stored words and working copies
  word_t zero_point_offset;
  word_t quad_config;
  logic [1:0] lock_code;
  logic [1:0] diag_disable_bits;
  logic [6:0] comm_config;

  word_t work_zero_point;
  word_t work_quad_config;
  logic [1:0] work_diag;
  logic [6:0] work_comm_config;

  // ============================================================
  // Lock state and address decode
  logic unlocked;
  logic wr_hit;

  assign unlocked = (lock_code == `LOCK_OPEN);

  always_comb begin
    if (mem_addr_in == `ADDR_ZERO_POINT) begin
      wr_hit = 1'b1;
    end else if (mem_addr_in == `ADDR_QUAD_CONFIG) begin
      wr_hit = 1'b1;
    end else if (mem_addr_in == `ADDR_LOCK) begin
      wr_hit = 1'b1;
    end else if (mem_addr_in == `ADDR_DIAG) begin
      wr_hit = 1'b1;
    end else if (mem_addr_in == `ADDR_COMM_CONFIG) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // ============================================================
  // Stored memory, writable only while the lock field is open
  // A lock write closes the field at its own edge; status lags one edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zero_point_offset <= `RST_ZERO_POINT;
      quad_config <= `RST_QUAD_CONFIG;
      lock_code <= `RST_LOCK;
      diag_disable_bits <= `RST_DIAG;
      comm_config <= `RST_COMM_CONFIG;
    end else if (mem_wr_in && unlocked) begin // [RULE_02]
      if (mem_addr_in == `ADDR_ZERO_POINT) begin
        zero_point_offset <= mem_wdata_in;
      end else if (mem_addr_in == `ADDR_QUAD_CONFIG) begin
        quad_config <= {2'h0, mem_wdata_in[9:0]};
      end else if (mem_addr_in == `ADDR_LOCK) begin
        lock_code <= mem_wdata_in[1:0]; // [RULE_02]
      end else if (mem_addr_in == `ADDR_DIAG) begin
        diag_disable_bits <= mem_wdata_in[1:0];
      end else if (mem_addr_in == `ADDR_COMM_CONFIG) begin
        comm_config <= mem_wdata_in[6:0];
      end
    end
  end

  // ============================================================
  // Write refusal and lock state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_wr_refused_out <= 1'b0;
      mem_locked_out <= 1'b0;
    end else begin
      mem_wr_refused_out <= mem_wr_in && (!unlocked || !wr_hit); // [RULE_02]
      mem_locked_out <= !unlocked;
    end
  end

  // ============================================================
  // Read port, unmapped addresses read zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_rdata_out <= 12'h000;
    end else if (mem_rd_in) begin
      if (mem_addr_in == `ADDR_ZERO_POINT) begin
        mem_rdata_out <= zero_point_offset;
      end else if (mem_addr_in == `ADDR_QUAD_CONFIG) begin
        mem_rdata_out <= quad_config;
      end else if (mem_addr_in == `ADDR_LOCK) begin
        mem_rdata_out <= {10'h000, lock_code};
      end else if (mem_addr_in == `ADDR_DIAG) begin
        mem_rdata_out <= {10'h000, diag_disable_bits};
      end else if (mem_addr_in == `ADDR_COMM_CONFIG) begin
        mem_rdata_out <= {5'h00, comm_config};
      end else begin
        mem_rdata_out <= 12'h000;
      end
    end
  end

  // ============================================================
  // Working copies load at power-up (reset) and normal-mode entry
  // Stored words never reach the pins or diagnosis enables between entries
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      work_zero_point <= `RST_ZERO_POINT; // [RULE_19]
      work_quad_config <= `RST_QUAD_CONFIG;
      work_diag <= `RST_DIAG;
      work_comm_config <= `RST_COMM_CONFIG;
    end else if (normal_mode_entry_in) begin
      work_zero_point <= zero_point_offset; // [RULE_19]
      work_quad_config <= quad_config;
      work_diag <= diag_disable_bits;
      work_comm_config <= comm_config;
    end
  end

  // ============================================================
  // Diagnosis enables
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flux_check_en_out <= 1'b1;
      tracking_check_en_out <= 1'b1;
    end else begin
      flux_check_en_out <= !work_diag[1]; // [RULE_03]
      tracking_check_en_out <= !work_diag[0]; // [RULE_03]
    end
  end

  // ============================================================
  // Corrected angle
  word_t offset_angle;
  word_t corrected_angle;

  always_comb begin
    offset_angle = absolute_angle_in - work_zero_point; // [RULE_20] [RULE_08] [RULE_11]
    if (work_quad_config[`QC_DIR_BIT]) begin
      corrected_angle = 12'h000 - offset_angle; // [RULE_20]
    end else begin
      corrected_angle = offset_angle;
    end
  end

  // ============================================================
  // Per-group hysteresis filters
  word_t quad_angle;
  word_t comm_angle;

  angle_hysteresis_filter #(
    .WIDTH(12)
  ) quad_filter (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .hys_code_in(work_quad_config[`QC_HYS_MSB:`QC_HYS_LSB]),
    .angle_in(corrected_angle),
    .angle_out(quad_angle)
  );

  angle_hysteresis_filter #(
    .WIDTH(12)
  ) comm_filter (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .hys_code_in(work_comm_config[`CC_HYS_MSB:`CC_HYS_LSB]), // [RULE_12] [RULE_05]
    .angle_in(corrected_angle),
    .angle_out(comm_angle)
  );

  // ============================================================
  // Scaling
  function automatic logic [10:0] quad_ppr(input logic [3:0] code);
    logic [10:0] ppr;
    ppr = 11'h400;
    case (code)
      4'h0: ppr = 11'h400;
      4'h1: ppr = 11'h200;
      4'h2: ppr = 11'h100;
      4'h3: ppr = 11'h080;
      4'h4: ppr = 11'h3e8;
      4'h5: ppr = 11'h384;
      4'h6: ppr = 11'h320;
      4'h7: ppr = 11'h2bc;
      4'h8: ppr = 11'h258;
      4'h9: ppr = 11'h1f4;
      4'ha: ppr = 11'h190;
      4'hb: ppr = 11'h168;
      4'hc: ppr = 11'h12c;
      4'hd: ppr = 11'h0c8;
      4'he: ppr = 11'h064;
      default: ppr = 11'h032;
    endcase
    return ppr;
  endfunction

  logic [24:0] quad_product;
  word_t scaled_quadrature_angle;
  logic [3:0] comm_pulses;
  logic [5:0] comm_factor;
  logic [17:0] comm_product;
  logic [5:0] scaled_commutation_angle;
  logic [2:0] comm_phase;

  always_comb begin
    quad_product = {1'b0, quad_angle} * {quad_ppr(work_quad_config[`QC_RES_MSB:`QC_RES_LSB]), 2'b00}; // [RULE_01] [RULE_09]
    scaled_quadrature_angle = quad_product[23:12]; // [RULE_09]
    comm_pulses = {1'b0, work_comm_config[`CC_CNT_MSB:`CC_CNT_LSB]} + 4'h1; // [RULE_06]
    comm_factor = {comm_pulses, 2'b00} + {1'b0, comm_pulses, 1'b0};
    comm_product = comm_angle * comm_factor; // [RULE_13]
    scaled_commutation_angle = comm_product[17:12]; // [RULE_13]
    comm_phase = 3'(scaled_commutation_angle % 6'd6);
  end

  // ============================================================
  // Registered pin levels and enables
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quad_a_out <= 1'b0;
      quad_b_out <= 1'b0;
      quad_z_out <= 1'b0;
      quad_oe_out <= 1'b1;
    end else begin
      quad_a_out <= scaled_quadrature_angle[1]; // [RULE_10] [RULE_21]
      quad_b_out <= scaled_quadrature_angle[1] ^ scaled_quadrature_angle[0]; // [RULE_10]
      if (work_quad_config[`QC_ZMODE_BIT]) begin
        quad_z_out <= !quad_angle[11]; // [RULE_07]
      end else begin
        quad_z_out <= ~|scaled_quadrature_angle; // [RULE_07] [RULE_10]
      end
      quad_oe_out <= work_quad_config[`QC_EN_BIT]; // [RULE_18]
    end
  end

  // ============================================================
  // Commutation pin levels and enable
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      comm_u_out <= 1'b0;
      comm_v_out <= 1'b0;
      comm_w_out <= 1'b1;
      comm_oe_out <= 1'b1;
    end else begin
      comm_u_out <= (comm_phase < 3'd2); // [RULE_14] [RULE_21]
      comm_v_out <= (comm_phase == 3'd2) || (comm_phase == 3'd3); // [RULE_15]
      comm_w_out <= !((comm_phase == 3'd1) || (comm_phase == 3'd2)); // [RULE_16]
      comm_oe_out <= work_comm_config[`CC_EN_BIT]; // [RULE_04]
    end
  end

endmodule

// File: verification/encoder_output_sva.sv
// Checker for the encoder output block: memory lock, refusals, settings load, commutation code.
// Assumes it is bound to abz_uvw_encoder_output and sees only its ports.
`timescale 1ns/1ps

module encoder_output_sva (
  // Clock, reset and requests
  input wire logic clk_in, nrst_in, mem_wr_in, mem_rd_in, normal_mode_entry_in,
  input wire logic [3:0] mem_addr_in,
  input wire logic [11:0] mem_wdata_in, mem_rdata_out,
  // Status and pins
  input wire logic mem_wr_refused_out, mem_locked_out, flux_check_en_out, tracking_check_en_out,
  input wire logic quad_oe_out, comm_oe_out, comm_u_out, comm_v_out, comm_w_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic mapped;
  assign mapped = mem_addr_in >= 4'h6 && mem_addr_in <= 4'ha;
  logic lock_req;
  assign lock_req = mem_wr_in && mem_addr_in == 4'h8 && mem_wdata_in[1:0] != 2'h3;

  // ==========================================
  // Sequences
  sequence s_locked_wr;
    mem_locked_out && mem_wr_in;
  endsequence
  sequence s_no_entry;
    !normal_mode_entry_in ##1 !normal_mode_entry_in;
  endsequence

  // ==========================================
  // Properties
  property p_lock_refuse;
    s_locked_wr |=> mem_wr_refused_out;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked write not refused");
  property p_lock_sticky;
    mem_locked_out |=> mem_locked_out;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");
  property p_lock_set;
    !mem_locked_out && lock_req |=> ##1 mem_locked_out;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not taken");
  property p_open_ok;
    !mem_locked_out && !$past(lock_req) && mem_wr_in && mapped |=> !mem_wr_refused_out;
  endproperty
  a_open_ok: assert property (p_open_ok) else $error("open write refused");
  property p_unmapped_rd;
    mem_rd_in && !mapped |=> mem_rdata_out == 12'h000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_no_wr;
    !mem_wr_in |=> !mem_wr_refused_out;
  endproperty
  a_no_wr: assert property (p_no_wr) else $error("refusal without write");
  property p_settings_hold;
    s_no_entry |=> $stable(quad_oe_out) && $stable(comm_oe_out) && $stable(flux_check_en_out)
      && $stable(tracking_check_en_out);
  endproperty
  a_settings_hold: assert property (p_settings_hold) else $error("settings changed without entry");
  property p_uvw_code;
    !(comm_u_out && comm_v_out) && (comm_u_out || comm_v_out || comm_w_out);
  endproperty
  a_uvw_code: assert property (p_uvw_code) else $error("illegal commutation code");
endmodule

bind abz_uvw_encoder_output encoder_output_sva u_sva (.clk_in, .nrst_in, .mem_wr_in, .mem_rd_in,
  .normal_mode_entry_in, .mem_addr_in, .mem_wdata_in, .mem_rdata_out, .mem_wr_refused_out,
  .mem_locked_out, .flux_check_en_out, .tracking_check_en_out, .quad_oe_out, .comm_oe_out,
  .comm_u_out, .comm_v_out, .comm_w_out);

// File: verification/pin_receiver.sv
// Far side model: the drive's pin receivers for A, B, Z, U, V, W.
// Assumes one enable bit per pin, high while the block drives it.
`timescale 1ns/1ps

module pin_receiver (
  input wire logic clk_in,
  input wire logic [5:0] lvl_in,
  input wire logic [5:0] oe_in,
  output logic [5:0] seen_out
);
  logic [5:0] last;
  always_ff @(posedge clk_in) begin
    last <= seen_out;
  end
  // Released pin shows a toggling level, never the old one
  assign seen_out = (oe_in & lvl_in) | (~oe_in & ~last);
endmodule

// File: verification/tb.sv
// Testbench for the encoder output block with random angles and settings.
// Assumes the checker binds itself and the pin receiver models the drive.
`timescale 1ns/1ps

module tb;
  logic clk_in = 0, nrst_in = 0, entry = 0, wr = 0, rd = 0, qa, qb, qz, qoe, cu, cv, cw, coe;
  logic lk, fe, te, got_ref;
  logic [3:0] addr = 0;
  logic [11:0] wd = 0, absolute_angle = 0, got_rd, rdata, zp, q, c, rnd;
  logic [5:0] seen;
  logic refused;
  int seed = 35, n_fail = 0, samples_checked = 0;
  int ppr[16] = '{1024, 512, 256, 128, 1000, 900, 800, 700, 600, 500, 400, 360, 300, 200, 100, 50};
  logic [3:0] da[6] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'h4};
  logic [11:0] dv[6] = '{12'h000, 12'h0a0, 12'h003, 12'h000, 12'h052, 12'h000};
  always #20 clk_in = ~clk_in;

  abz_uvw_encoder_output dut (.clk_in(clk_in), .nrst_in(nrst_in), .absolute_angle_in(absolute_angle),
    .normal_mode_entry_in(entry), .mem_wr_in(wr), .mem_rd_in(rd), .mem_addr_in(addr),
    .mem_wdata_in(wd), .mem_rdata_out(rdata), .mem_wr_refused_out(refused), .mem_locked_out(lk),
    .flux_check_en_out(fe), .tracking_check_en_out(te), .quad_a_out(qa), .quad_b_out(qb),
    .quad_z_out(qz), .quad_oe_out(qoe), .comm_u_out(cu), .comm_v_out(cv), .comm_w_out(cw),
    .comm_oe_out(coe));
  pin_receiver far (.clk_in(clk_in), .lvl_in({qa, qb, qz, cu, cv, cw}), .oe_in({{3{qoe}}, {3{coe}}}),
    .seen_out(seen));

  // ==========================================
  // Tasks and expectation
  task step(int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task chk(string s, logic [11:0] e, logic [11:0] g);
    samples_checked++;
    if (e !== g) begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask
  task acc(logic w, logic [3:0] a, logic [11:0] d);
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    step(1);
    got_rd = rdata;
    got_ref = refused;
    wr = 0;
    rd = 0;
    step(1);
  endtask
  task cfg(logic [11:0] z, logic [11:0] qq, logic [11:0] cc);
    acc(1, 4'h6, z);
    acc(1, 4'h7, qq);
    acc(1, 4'ha, cc);
    entry = 1;
    step(1);
    entry = 0;
    step(1);
  endtask
  function logic [5:0] pins(logic [11:0] an, logic [11:0] z, logic [11:0] qq, logic [11:0] cc);
    logic [11:0] cr;
    int qs, ph;
    cr = an - z;
    if (qq[9]) cr = -cr;
    qs = (cr * ppr[qq[3:0]] * 4) >> 12;
    ph = ((cr * 6 * (cc[2:0] + 1)) >> 12) % 6;
    return {qs[1], qs[1] ^ qs[0], qq[8] ? !cr[11] : qs == 0, ph < 2, ph == 2 || ph == 3, !(ph == 1 || ph == 2)};
  endfunction
  task run(logic [11:0] an, logic [11:0] h);
    absolute_angle = an;
    step(3);
    chk("pins", {6'h0, pins(h, zp, q, c)}, {6'h0, seen});
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================
  // Sequence
  initial begin
    #400000;
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk_in);
    #2 nrst_in = 1;
    for (int i = 0; i < 6; i++) begin
      acc(0, da[i], 12'h000);
      chk("rd", dv[i], got_rd);
    end
    chk("oe_en", 12'h00f, {8'h0, qoe, coe, fe, te});
    acc(1, 4'h4, 12'h555);
    chk("ref", 12'h001, {11'h0, got_ref});
    for (int i = 0; i < 32; i++) begin
      zp = $random(seed);
      q = 12'h080 | (i < 16 ? i[11:0] : $random(seed) & 12'h30f);
      c = 12'h040 | i[2:0];
      cfg(zp, q, c);
      for (int j = 0; j < 4; j++) begin
        rnd = j == 0 ? zp : $random(seed);
        run(rnd, rnd);
        step(2);
        chk("pins_hold", {6'h0, pins(rnd, zp, q, c)}, {6'h0, seen});
      end
    end
    zp = 0;
    q = 12'h090;
    c = 12'h048;
    cfg(zp, q, c);
    run(12'd100, 12'd100);
    run(12'd101, 12'd100);
    run(12'd102, 12'd102);
    acc(1, 4'h7, 12'h000);
    acc(1, 4'ha, 12'h002);
    acc(1, 4'h9, 12'h003);
    chk("oe_en", 12'h00f, {8'h0, qoe, coe, fe, te});
    cfg(zp, 12'h000, 12'h002);
    chk("oe_en", 12'h000, {8'h0, qoe, coe, fe, te});
    acc(1, 4'h8, 12'h001);
    chk("lock", 12'h001, {11'h0, lk});
    acc(1, 4'h6, 12'h123);
    chk("ref", 12'h001, {11'h0, got_ref});
    acc(1, 4'h8, 12'h003);
    chk("ref", 12'h001, {11'h0, got_ref});
    acc(0, 4'h8, 12'h000);
    chk("rd", 12'h001, got_rd);
    acc(0, 4'h6, 12'h000);
    chk("rd", 12'h000, got_rd);
    give_verdict;
  end
endmodule
